// ===== verilog/itd_defs.vh
// Constants for the interpolate/test-and-set/trap decoder
`ifndef ITD_DEFS_VH
`define ITD_DEFS_VH
`define ITD_TRAP_VEC_BASE 8'h20
`define ITD_COND_TRAP_VEC 8'h07
`define ITD_FORM_WORD 3'h2
`define ITD_FORM_LONG 3'h3
`define ITD_FORM_NONE 3'h4
`define ITD_SIZE_BYTE 2'h0
`define ITD_SIZE_WORD 2'h1
`define ITD_SIZE_LONG 2'h2
`define ITD_ADDR_STATUS 12'h000
`define ITD_ADDR_MASK 12'h004
`define ITD_ADDR_FLAGS 12'h008
`define ITD_ADDR_DECODE 12'h00C
`define ITD_ADDR_VECTOR 12'h010
`define ITD_ADDR_STACK 12'h014
`define ITD_ADDR_PC 12'h018
`define ITD_ADDR_SR 12'h01C
`define ITD_EV_TRAP 0
`define ITD_EV_TSET 1
`define ITD_EV_ILLEGAL 2
`define ITD_EV_INTERP 3
`define ITD_FMT_SHIFT 4'h2
`endif

// ===== verilog/itd_decoder.v
// Decoder and sequencer for interpolate, test-and-set and trap opcodes
`timescale 1ns/10ps
`include "itd_defs.vh"

module itd_decoder (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg irq,
    output reg mem_req,
    output reg mem_we,
    output reg mem_lock,
    output reg [1:0] mem_size,
    output reg [31:0] mem_addr,
    output reg [31:0] mem_wdata,
    input wire [31:0] mem_rdata,
    input wire mem_ack
);
    localparam ST_IDLE = 3'h0;
    localparam ST_TSET_RD = 3'h1;
    localparam ST_TSET_WR = 3'h2;
    localparam ST_PUSH_FMT = 3'h3;
    localparam ST_PUSH_PC = 3'h4;
    localparam ST_PUSH_SR = 3'h5;
    localparam ST_VEC_RD = 3'h6;

    reg [3:0] status;
    reg [3:0] mask;
    reg [4:0] flags;
    reg [31:0] opword;
    reg [31:0] ea_addr;
    reg [31:0] supervisor_stack_ptr;
    reg [31:0] pc;
    reg [15:0] sr;
    reg [7:0] vector;
    reg [2:0] state;
    reg [3:0] dest_data_reg;
    reg [2:0] src_reg_y;
    reg [1:0] interp_size;
    reg interp_reg_mode;
    reg interp_unrounded;
    reg [1:0] form_len;
    reg [3:0] ev_set;

    wire wr_acc = psel && penable && pwrite;
    wire [15:0] op = opword[31:16];
    wire [15:0] ext = opword[15:0];
    wire [2:0] ea_mode = op[5:3];
    wire [2:0] ea_reg = op[2:0];
    wire go = wr_acc && paddr == `ITD_ADDR_DECODE && state == ST_IDLE;
    wire [15:0] gop = pwdata[31:16];
    wire [15:0] gext = pwdata[15:0];

    // Flags are X N Z V C in bits 4..0
    wire fx = flags[4];
    wire fn = flags[3];
    wire fz = flags[2];
    wire fv = flags[1];
    wire fc = flags[0];

    reg cond_true;
    always @* begin
        case (gop[11:8])
            4'h0: cond_true = 1'b1;
            4'h1: cond_true = 1'b0;
            4'h2: cond_true = !fc && !fz;
            4'h3: cond_true = fc || fz;
            4'h4: cond_true = !fc;
            4'h5: cond_true = fc;
            4'h6: cond_true = !fz;
            4'h7: cond_true = fz;
            4'h8: cond_true = !fv;
            4'h9: cond_true = fv;
            4'hA: cond_true = !fn;
            4'hB: cond_true = fn;
            4'hC: cond_true = fn == fv;
            4'hD: cond_true = fn != fv;
            4'hE: cond_true = (fn == fv) && !fz;
            4'hF: cond_true = fz || (fn != fv);
            default: cond_true = 1'b0;
        endcase
    end

    // Opcode classes
    wire is_trap = gop[15:4] == 12'h4E4;
    wire is_test_set = gop[15:6] == 10'h12B;
    wire is_cond_trap = gop[15:12] == 4'h5 && gop[7:3] == 5'h1F &&
        (gop[2:0] == `ITD_FORM_WORD || gop[2:0] == `ITD_FORM_LONG ||
         gop[2:0] == `ITD_FORM_NONE);
    wire is_interp = gop[15:6] == 10'h3E0 && gext[15] == 1'b0 &&
        gext[11] == 1'b0 && gext[9] == 1'b0 && gext[5:3] == 3'h0;
    wire [2:0] gmode = gop[5:3];
    wire [2:0] greg = gop[2:0];
    // Control modes only; register direct handled as register form
    wire interp_ea_ok = gmode == 3'h0 ||
        ((gmode == 3'h2 || gmode == 3'h5 || gmode == 3'h6 ||
          (gmode == 3'h7 && greg <= 3'h3)) && gext[8] == 1'b1 &&
          gext[2:0] == 3'h0);
    wire test_set_ea_ok = gmode != 3'h1 &&
        (gmode != 3'h7 || greg <= 3'h1);
    wire size_ok = gext[7:6] != 2'h3;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= 4'h0;
            mask <= 4'h0;
            flags <= 5'h00;
            opword <= 32'h0;
            ea_addr <= 32'h0;
            supervisor_stack_ptr <= 32'h0;
            pc <= 32'h0;
            sr <= 16'h2700;
            vector <= 8'h00;
            state <= ST_IDLE;
            dest_data_reg <= 4'h0;
            src_reg_y <= 3'h0;
            interp_size <= 2'h0;
            interp_reg_mode <= 1'b0;
            interp_unrounded <= 1'b0;
            form_len <= 2'h0;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_lock <= 1'b0;
            mem_size <= 2'h0;
            mem_addr <= 32'h0;
            mem_wdata <= 32'h0;
            ev_set <= 4'h0;
        end else begin
            ev_set <= 4'h0;
            if (wr_acc) begin
                case (paddr)
                    `ITD_ADDR_MASK: mask <= pwdata[3:0];
                    `ITD_ADDR_FLAGS: flags <= pwdata[4:0];
                    `ITD_ADDR_VECTOR: ea_addr <= pwdata;
                    `ITD_ADDR_STACK: supervisor_stack_ptr <= pwdata;
                    `ITD_ADDR_PC: pc <= pwdata;
                    `ITD_ADDR_SR: sr <= pwdata[15:0];
                    default: ;
                endcase
            end
            // Set wins over a write-one clear in the same cycle
            status <= (status & ~((wr_acc && paddr == `ITD_ADDR_STATUS) ?
                pwdata[3:0] : 4'h0)) | ev_set;
            if (go) begin
                opword <= pwdata;
                if (is_trap) begin
                    vector <= `ITD_TRAP_VEC_BASE + {4'h0, gop[3:0]};
                    pc <= pc + 32'h2;
                    state <= ST_PUSH_FMT;
                    ev_set[`ITD_EV_TRAP] <= 1'b1;
                end else if (is_cond_trap) begin
                    case (gop[2:0])
                        `ITD_FORM_WORD: form_len <= 2'h1;
                        `ITD_FORM_LONG: form_len <= 2'h2;
                        default: form_len <= 2'h0;
                    endcase
                    // Next instruction follows any operand words
                    pc <= pc + 32'h2 + ((gop[2:0] == `ITD_FORM_WORD) ?
                        32'h2 : (gop[2:0] == `ITD_FORM_LONG) ? 32'h4 : 32'h0);
                    if (cond_true) begin
                        vector <= `ITD_COND_TRAP_VEC;
                        state <= ST_PUSH_FMT;
                        ev_set[`ITD_EV_TRAP] <= 1'b1;
                    end
                end else if (is_test_set && test_set_ea_ok) begin
                    if (gmode == 3'h0) begin
                        // Data register operand: no bus cycle
                        ev_set[`ITD_EV_TSET] <= 1'b1;
                    end else begin
                        mem_req <= 1'b1;
                        mem_we <= 1'b0;
                        mem_lock <= 1'b1;
                        mem_size <= `ITD_SIZE_BYTE;
                        mem_addr <= ea_addr;
                        state <= ST_TSET_RD;
                    end
                end else if (is_interp && interp_ea_ok && size_ok) begin
                    interp_reg_mode <= gmode == 3'h0;
                    src_reg_y <= gext[2:0];
                    dest_data_reg <= {1'b0, gext[14:12]};
                    interp_size <= gext[7:6];
                    interp_unrounded <= gext[10];
                    ev_set[`ITD_EV_INTERP] <= 1'b1;
                end else begin
                    ev_set[`ITD_EV_ILLEGAL] <= 1'b1;
                end
            end
            case (state)
                ST_TSET_RD: if (mem_ack) begin
                    // Lock stays up across read and write
                    flags <= {fx, mem_rdata[7], mem_rdata[7:0] == 8'h00,
                        2'b00};
                    mem_we <= 1'b1;
                    mem_wdata <= {24'h0, 1'b1, mem_rdata[6:0]};
                    state <= ST_TSET_WR;
                end
                ST_TSET_WR: if (mem_ack) begin
                    mem_req <= 1'b0;
                    mem_we <= 1'b0;
                    mem_lock <= 1'b0;
                    ev_set[`ITD_EV_TSET] <= 1'b1;
                    state <= ST_IDLE;
                end
                ST_PUSH_FMT: begin
                    if (!mem_req) begin
                        mem_req <= 1'b1;
                        mem_we <= 1'b1;
                        mem_size <= `ITD_SIZE_WORD;
                        mem_addr <= supervisor_stack_ptr - 32'h2;
                        mem_wdata <= {16'h0, 4'h0, vector, `ITD_FMT_SHIFT};
                        supervisor_stack_ptr <= supervisor_stack_ptr - 32'h2;
                    end else if (mem_ack) begin
                        mem_size <= `ITD_SIZE_LONG;
                        mem_addr <= supervisor_stack_ptr - 32'h4;
                        mem_wdata <= pc;
                        supervisor_stack_ptr <= supervisor_stack_ptr - 32'h4;
                        state <= ST_PUSH_PC;
                    end
                end
                ST_PUSH_PC: if (mem_ack) begin
                    mem_size <= `ITD_SIZE_WORD;
                    mem_addr <= supervisor_stack_ptr - 32'h2;
                    mem_wdata <= {16'h0, sr};
                    supervisor_stack_ptr <= supervisor_stack_ptr - 32'h2;
                    state <= ST_PUSH_SR;
                end
                ST_PUSH_SR: if (mem_ack) begin
                    mem_we <= 1'b0;
                    mem_size <= `ITD_SIZE_LONG;
                    mem_addr <= {22'h0, vector, 2'b00};
                    state <= ST_VEC_RD;
                end
                ST_VEC_RD: if (mem_ack) begin
                    pc <= mem_rdata;
                    mem_req <= 1'b0;
                    state <= ST_IDLE;
                end
                default: ;
            endcase
        end
    end

    // Zero-wait APB, reads registered in the setup cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            irq <= 1'b0;
        end else begin
            irq <= |(status & mask);
            pready <= psel && !penable;
            pslverr <= psel && !penable && paddr > `ITD_ADDR_SR;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    `ITD_ADDR_STATUS: prdata <= {28'h0, status};
                    `ITD_ADDR_MASK: prdata <= {28'h0, mask};
                    `ITD_ADDR_FLAGS: prdata <= {27'h0, flags};
                    `ITD_ADDR_DECODE: prdata <= {state != ST_IDLE, 9'h0,
                        form_len, interp_unrounded, interp_reg_mode,
                        interp_size, src_reg_y, dest_data_reg, 1'b0, vector};
                    `ITD_ADDR_VECTOR: prdata <= ea_addr;
                    `ITD_ADDR_STACK: prdata <= supervisor_stack_ptr;
                    `ITD_ADDR_PC: prdata <= pc;
                    `ITD_ADDR_SR: prdata <= {16'h0, sr};
                    default: prdata <= 32'h0;
                endcase
            end
        end
    end
endmodule

// ===== verification/itd_decoder_properties.sv
// Port checker for the interpolate, test-and-set and trap decoder
`timescale 1ns/10ps
module itd_decoder_properties (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire irq,
    input wire mem_req,
    input wire mem_we,
    input wire mem_lock,
    input wire [1:0] mem_size,
    input wire [31:0] mem_addr,
    input wire [31:0] mem_wdata,
    input wire [31:0] mem_rdata,
    input wire mem_ack
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence tset_rd;
        mem_req && mem_lock && !mem_we && mem_ack;
    endsequence
    sequence tset_wr;
        mem_req && mem_we && mem_lock && mem_wdata[7];
    endsequence
    sequence pc_push;
        mem_req && mem_we && mem_size == 2'h2 && mem_ack;
    endsequence
    sequence sr_push;
        mem_req && mem_we && mem_size == 2'h1 && mem_ack;
    endsequence
    sequence vec_rd;
        mem_req && !mem_we && mem_size == 2'h2 && mem_ack;
    endsequence
    chk_setup_ready: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    chk_ready_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    chk_slverr_range: assert property
        (psel && !penable && paddr > 12'h01C |=> pslverr)
        else $error("unmapped access not refused");
    chk_lock_byte: assert property
        (mem_req && mem_lock |-> mem_size == 2'h0)
        else $error("locked beat not byte");
    chk_tset_rmw: assert property
        (tset_rd |=> mem_lock throughout (##[0:20] tset_wr))
        else $error("lock dropped or top bit not set");
    chk_stack_order: assert property
        (pc_push |=> ##[0:20] sr_push ##[1:20] vec_rd)
        else $error("stacking order wrong");
    chk_vector_addr: assert property
        (vec_rd |-> mem_addr == 32'h0000001C ||
            (mem_addr[31:6] == 26'h2 && mem_addr[1:0] == 2'h0))
        else $error("vector fetch address wrong");
    chk_reset_quiet: assert property ($rose(presetn) |-> !irq && !mem_req)
        else $error("outputs active after reset");
    chk_ready_once: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
endmodule
bind itd_decoder itd_decoder_properties u_props (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .mem_req(mem_req), .mem_we(mem_we),
    .mem_lock(mem_lock), .mem_size(mem_size), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

// ===== verification/itd_mem_model.sv
// Behavioural memory on the decoder's bus port, byte addressed, big endian
`timescale 1ns/10ps
module itd_mem_model (
    input wire pclk,
    input wire slow,
    input wire mem_req,
    input wire mem_we,
    input wire [1:0] mem_size,
    input wire [31:0] mem_addr,
    input wire [31:0] mem_wdata,
    output logic [31:0] mem_rdata,
    output logic mem_ack
);
    logic [7:0] m [int];
    int wait_n = 0;
    int n;
    function automatic logic [31:0] rd(input int a, input int k);
        logic [31:0] v;
        v = 32'h0;
        for (int i = 0; i < k; i++)
            v = {v[23:0], m.exists(a + i) ? m[a + i] : 8'(a + i) ^ 8'h5A};
        return v;
    endfunction
    initial begin
        mem_ack = 1'b0;
        mem_rdata = 32'h0;
    end
    always @(posedge pclk) begin
        mem_ack <= 1'b0;
        // Released data lines never show the last value
        mem_rdata <= ~mem_rdata;
        if (mem_req && !mem_ack) begin
            if (wait_n < (slow ? 3 : 0)) begin
                wait_n <= wait_n + 1;
            end else begin
                wait_n <= 0;
                mem_ack <= 1'b1;
                n = 1 << mem_size;
                if (mem_we) begin
                    for (int i = 0; i < n; i++)
                        m[mem_addr + i] = 8'(mem_wdata >> (8 * (n - 1 - i)));
                end else begin
                    mem_rdata <= rd(mem_addr, n);
                end
            end
        end
    end
endmodule

// ===== verification/tb_interp_testset_trap_decode.sv
// Self-checking bench for the interpolate, test-and-set and trap decoder
`timescale 1ns/10ps
module tb_interp_testset_trap_decode;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic slow = 0, e, pready, pslverr, irq, mem_req, mem_we, mem_lock;
    logic mem_ack;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, r, prdata, mem_rdata, mem_addr, mem_wdata;
    logic [1:0] mem_size;
    int errors = 0, checks_done = 0;
    always #4 pclk = ~pclk;
    itd_decoder u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .mem_req(mem_req), .mem_we(mem_we), .mem_lock(mem_lock),
        .mem_size(mem_size), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack));
    itd_mem_model u_mem (.pclk(pclk), .slow(slow), .mem_req(mem_req),
        .mem_we(mem_we), .mem_size(mem_size), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
    task close_out;
        if (errors == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h",
                $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
            errors++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task run(input logic [31:0] op);
        int n;
        n = 0;
        apb(1'b1, 12'h00C, op);
        do begin
            apb(1'b0, 12'h00C, 32'h0);
            n++;
        end while (r[31] !== 1'b0 && n < 200);
        if (r[31] !== 1'b0)
            errors++;
    endtask
    // Flags are {N, Z, V, C}; odd codes invert the even code below them
    function automatic logic cc_true(input logic [3:0] c, input logic [3:0] f);
        logic b;
        case (c[3:1])
            3'h0: b = 1'b1;
            3'h1: b = !f[0] && !f[2];
            3'h2: b = !f[0];
            3'h3: b = !f[2];
            3'h4: b = !f[1];
            3'h5: b = !f[3];
            3'h6: b = f[3] == f[1];
            default: b = f[3] == f[1] && !f[2];
        endcase
        return b ^ c[0];
    endfunction
    task trap_chk(input logic [31:0] op, input logic take, input int vec,
        input int adv);
        apb(1'b1, 12'h000, 32'h0000000F);
        apb(1'b1, 12'h014, 32'h00001000);
        apb(1'b1, 12'h018, 32'h00000400);
        run(op);
        apb(1'b0, 12'h000, 32'h0);
        cmp(r[0], take);
        if (take) begin
            apb(1'b0, 12'h018, 32'h0);
            cmp(r, u_mem.rd(vec * 4, 4));
            cmp(u_mem.rd(4090, 4), 32'h400 + adv);
            apb(1'b0, 12'h014, 32'h0);
            cmp(r, 32'h00000FF8);
        end
    endtask
    task t_test_set;
        logic [7:0] v;
        for (int i = 0; i < 2; i++) begin
            v = i ? 8'hC3 : 8'h00;
            u_mem.m[512] = v;
            apb(1'b1, 12'h008, 32'h0000001F);
            apb(1'b1, 12'h010, 32'h00000200);
            run(32'h4AD00000);
            cmp(u_mem.m[512], v | 8'h80);
            apb(1'b0, 12'h008, 32'h0);
            cmp(r, {27'h0, 1'b1, v[7], v == 8'h00, 2'b00});
        end
    endtask
    task t_illegal;
        logic [31:0] ops [4] = '{32'h4AC80000, 32'h4AFC0000, 32'hF8183140,
            32'hF83C3140};
        apb(1'b1, 12'h004, 32'h00000004);
        foreach (ops[i]) begin
            apb(1'b1, 12'h000, 32'h0000000F);
            run(ops[i]);
            apb(1'b0, 12'h000, 32'h0);
            cmp(r[2], 1'b1);
            cmp(irq, 1'b1);
        end
        apb(1'b1, 12'h000, 32'h0000000F);
        @(posedge pclk);
        cmp(irq, 1'b0);
        apb(1'b0, 12'h020, 32'h0);
        cmp(e, 1'b1);
    endtask
    task t_interp;
        for (int s = 0; s < 3; s++) begin
            run({16'hF805, 1'b0, 3'h6, 1'b0, s[0], 2'b00, s[1:0], 6'h03});
            cmp(r[19:13], {s[0],1'b1,s[1:0],3'h3});
            cmp(r[12:9], 4'h6);
        end
        apb(1'b1, 12'h000, 32'h0000000F);
        run(32'hF8103140);
        cmp(r[18], 1'b0);
        apb(1'b0, 12'h000, 32'h0);
        cmp(r[3:2], 2'b10);
    endtask
    task t_trap;
        trap_chk(32'h4E400000, 1'b1, 32, 2);
        slow <= 1'b1;
        trap_chk(32'h4E4F0000, 1'b1, 47, 2);
        slow <= 1'b0;
        for (int c = 0; c < 16; c++) begin
            for (int f = 5; f < 11; f += 5) begin
                apb(1'b1, 12'h008, 32'(f));
                trap_chk({16'h50FC | 16'(c << 8), 16'h0},
                    cc_true(4'(c), 4'(f)), 7, 2);
            end
        end
        trap_chk(32'h50FA1234, 1'b1, 7, 4);
        trap_chk(32'h50FB0000, 1'b1, 7, 6);
    endtask
    initial begin
        #200000;
        errors++;
        close_out;
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_test_set;
        t_illegal;
        t_interp;
        t_trap;
        close_out;
    end
endmodule
